// file: verilog/irq_regs_pkg.sv
// Register map, field layout and reset values of the interrupt enable and priority block
package irq_regs_pkg;

  localparam int ADDR_W     = 12;
  localparam int DATA_W     = 32;
  localparam int REG_W      = 16;
  localparam int PRIO_W     = 3;
  localparam int PRIO_REGS  = 3;
  localparam int PRIO_SRCS  = 11;
  localparam int FIELDS_REG = 4;
  localparam int FIELD_STEP = 4;

  // Byte offsets on the bus
  localparam logic [ADDR_W-1:0] IRQ_ENABLE_FOUR_OFS   = 12'h000;
  localparam logic [ADDR_W-1:0] IRQ_ENABLE_FIVE_OFS   = 12'h004;
  localparam logic [ADDR_W-1:0] IRQ_PRIORITY_ZERO_OFS = 12'h008;
  localparam logic [ADDR_W-1:0] IRQ_PRIORITY_ONE_OFS  = 12'h00C;
  localparam logic [ADDR_W-1:0] IRQ_PRIORITY_TWO_OFS  = 12'h010;

  // Enable bit positions, fourth register
  localparam int CHARGE_MEASURE_IRQ_EN  = 13;
  localparam int LOW_VOLTAGE_IRQ_EN     = 8;
  localparam int CHECKSUM_GEN_IRQ_EN    = 3;
  localparam int UART_TWO_ERROR_IRQ_EN  = 2;
  localparam int UART_ONE_ERROR_IRQ_EN  = 1;

  // Enable bit positions, fifth register
  localparam int CAPTURE_NINE_IRQ_EN      = 13;
  localparam int COMPARE_NINE_IRQ_EN      = 12;
  localparam int SPI_THREE_EVENT_IRQ_EN   = 11;
  localparam int SPI_THREE_FAULT_IRQ_EN   = 10;
  localparam int UART_FOUR_TX_IRQ_EN      = 9;
  localparam int UART_FOUR_RX_IRQ_EN      = 8;
  localparam int UART_FOUR_ERROR_IRQ_EN   = 7;
  localparam int USB_IRQ_EN               = 6;
  localparam int I2C_THREE_MASTER_IRQ_EN  = 5;
  localparam int I2C_THREE_SLAVE_IRQ_EN   = 4;
  localparam int UART_THREE_TX_IRQ_EN     = 3;
  localparam int UART_THREE_RX_IRQ_EN     = 2;
  localparam int UART_THREE_ERROR_IRQ_EN  = 1;

  // Implemented bits; everything else reads zero and ignores writes
  localparam logic [REG_W-1:0] ENABLE_FOUR_MASK   = 16'h210E;
  localparam logic [REG_W-1:0] ENABLE_FIVE_MASK   = 16'h3FFE;
  localparam logic [REG_W-1:0] PRIORITY_ZERO_MASK = 16'h7777;
  localparam logic [REG_W-1:0] PRIORITY_ONE_MASK  = 16'h7770;
  localparam logic [REG_W-1:0] PRIORITY_TWO_MASK  = 16'h7777;

  // Values after power-on reset
  localparam logic [REG_W-1:0] ENABLE_RESET        = 16'h0000;
  localparam logic [REG_W-1:0] PRIORITY_ZERO_RESET = 16'h4444;
  localparam logic [REG_W-1:0] PRIORITY_ONE_RESET  = 16'h4440;
  localparam logic [REG_W-1:0] PRIORITY_TWO_RESET  = 16'h4444;

  localparam logic [PRIO_W-1:0] PRIO_OFF     = 3'h0;
  localparam logic [PRIO_W-1:0] PRIO_LOWEST  = 3'h1;
  localparam logic [PRIO_W-1:0] PRIO_HIGHEST = 3'h7;

endpackage

// file: verilog/irq_enable_priority_regs.sv
// Interrupt enable and priority registers behind an APB slave
//
// Added by the designer: the placing of the registers and the APB slave port.
`timescale 1ns/10ps
module irq_enable_priority_regs
  import irq_regs_pkg::*;
(
  input  wire  logic                        clk,
  input  wire  logic                        rst_n,
  input  wire  logic                        psel,
  input  wire  logic                        penable,
  input  wire  logic                        pwrite,
  input  wire  logic [ADDR_W-1:0]           paddr,
  input  wire  logic [DATA_W-1:0]           pwdata,
  output logic       [DATA_W-1:0]           prdata,
  output logic                              pready,
  output logic                              pslverr,
  input  wire  logic [REG_W-1:0]            req_four,
  input  wire  logic [REG_W-1:0]            req_five,
  output logic       [REG_W-1:0]            pend_four,
  output logic       [REG_W-1:0]            pend_five,
  input  wire  logic [PRIO_SRCS-1:0]        prio_req,
  input  wire  logic [PRIO_SRCS-1:0]        prio_src_en,
  output logic       [PRIO_SRCS-1:0]        prio_pend,
  output logic       [PRIO_SRCS*PRIO_W-1:0] prio_level
);

  ////////////////////////////////////////////////////////////////////////////
  // Storage and decode

  logic [REG_W-1:0]  irq_enable_four;
  logic [REG_W-1:0]  irq_enable_five;
  logic [REG_W-1:0]  irq_priority [PRIO_REGS];
  logic [DATA_W-1:0] next_prdata;
  logic              hit;
  logic              setup;
  logic              wr_take;
  logic              prio_sel;
  logic [1:0]        prio_idx;
  logic [REG_W-1:0]  prio_mask [PRIO_REGS];

  assign prio_mask[0] = PRIORITY_ZERO_MASK;
  assign prio_mask[1] = PRIORITY_ONE_MASK;
  assign prio_mask[2] = PRIORITY_TWO_MASK;

  assign setup   = psel && !penable;
  assign wr_take = psel && penable && pready && pwrite && !pslverr;

  always_comb begin
    hit         = 1'b1;
    prio_sel    = 1'b0;
    prio_idx    = 2'h0;
    next_prdata = '0;
    unique case (paddr)
      IRQ_ENABLE_FOUR_OFS: begin
        next_prdata[REG_W-1:0] = irq_enable_four & ENABLE_FOUR_MASK;
      end
      IRQ_ENABLE_FIVE_OFS: begin
        next_prdata[REG_W-1:0] = irq_enable_five & ENABLE_FIVE_MASK;
      end
      IRQ_PRIORITY_ZERO_OFS: begin
        prio_sel = 1'b1;
        prio_idx = 2'h0;
      end
      IRQ_PRIORITY_ONE_OFS: begin
        prio_sel = 1'b1;
        prio_idx = 2'h1;
      end
      IRQ_PRIORITY_TWO_OFS: begin
        prio_sel = 1'b1;
        prio_idx = 2'h2;
      end
      default: begin
        hit = 1'b0;
      end
    endcase
    if (prio_sel) begin
      next_prdata[REG_W-1:0] = irq_priority[prio_idx] & prio_mask[prio_idx];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB answer: one cycle of setup, ready in the first access cycle

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else begin
      pready <= setup;
      if (setup) begin
        pslverr <= !hit;
        prdata  <= pwrite ? '0 : next_prdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register writes

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_enable_four <= ENABLE_RESET;
      irq_enable_five <= ENABLE_RESET;
    end else if (wr_take) begin
      if (paddr == IRQ_ENABLE_FOUR_OFS) begin
        irq_enable_four <= pwdata[REG_W-1:0] & ENABLE_FOUR_MASK;
      end
      if (paddr == IRQ_ENABLE_FIVE_OFS) begin
        irq_enable_five <= pwdata[REG_W-1:0] & ENABLE_FIVE_MASK;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_priority[0] <= PRIORITY_ZERO_RESET;
      irq_priority[1] <= PRIORITY_ONE_RESET;
      irq_priority[2] <= PRIORITY_TWO_RESET;
    end else if (wr_take && prio_sel) begin
      irq_priority[prio_idx] <= pwdata[REG_W-1:0] & prio_mask[prio_idx];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Request gating

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_four <= '0;
      pend_five <= '0;
    end else begin
      pend_four <= req_four & irq_enable_four & ENABLE_FOUR_MASK;
      pend_five <= req_five & irq_enable_five & ENABLE_FIVE_MASK;
    end
  end

  // Sources fill implemented fields top down; priority one lacks a lowest field
  genvar gi;
  generate
    for (gi = 0; gi < PRIO_SRCS; gi++) begin : g_src
      localparam int SKIP    = 2 * FIELDS_REG - 1;
      localparam int SLOT    = (gi < SKIP) ? gi : gi + 1;
      localparam int REG_IDX = SLOT / FIELDS_REG;
      localparam int LSB     = (FIELDS_REG - 1 - (SLOT % FIELDS_REG)) * FIELD_STEP;
      logic [PRIO_W-1:0] field;

      assign field = irq_priority[REG_IDX][LSB +: PRIO_W];

      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          prio_pend[gi]                  <= 1'b0;
          prio_level[gi*PRIO_W +: PRIO_W] <= PRIO_OFF;
        end else begin
          prio_pend[gi] <= prio_req[gi] && prio_src_en[gi] && (field != PRIO_OFF);
          prio_level[gi*PRIO_W +: PRIO_W] <= field;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  logic             first_cycle;
  logic [REG_W-1:0] rd_mask;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      first_cycle <= 1'b1;
    end else begin
      first_cycle <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_mask <= '0;
    end else if (setup) begin
      unique case (paddr)
        IRQ_ENABLE_FOUR_OFS:   rd_mask <= ENABLE_FOUR_MASK;
        IRQ_ENABLE_FIVE_OFS:   rd_mask <= ENABLE_FIVE_MASK;
        IRQ_PRIORITY_ZERO_OFS: rd_mask <= PRIORITY_ZERO_MASK;
        IRQ_PRIORITY_ONE_OFS:  rd_mask <= PRIORITY_ONE_MASK;
        IRQ_PRIORITY_TWO_OFS:  rd_mask <= PRIORITY_TWO_MASK;
        default:               rd_mask <= '0;
      endcase
    end
  end

  property p_gate_enable;
    pend_four == ($past(req_four) & $past(irq_enable_four));
  endproperty
  a_gate_enable: assert property (p_gate_enable) else $error("gated request mismatch");

  property p_unimpl_zero;
    (psel && penable && pready && !pwrite) |-> ((prdata[REG_W-1:0] & ~rd_mask) == '0)
                                               && (prdata[DATA_W-1:REG_W] == '0);
  endproperty
  a_unimpl_zero: assert property (p_unimpl_zero) else $error("unused bit read nonzero");

  property p_level_top;
    (irq_priority[0][14:12] == PRIO_HIGHEST) |=> (prio_level[0 +: PRIO_W] == 3'h7);
  endproperty
  a_level_top: assert property (p_level_top) else $error("code 111 not level 7");

  property p_level_low;
    (irq_priority[2][2:0] == PRIO_LOWEST) && prio_req[10] && prio_src_en[10]
      |=> prio_pend[10] && (prio_level[30 +: PRIO_W] == 3'h1);
  endproperty
  a_level_low: assert property (p_level_low) else $error("code 001 not level 1");

  property p_off_blocks;
    (irq_priority[1][6:4] == PRIO_OFF) |=> !prio_pend[6];
  endproperty
  a_off_blocks: assert property (p_off_blocks) else $error("disabled source pending");

  property p_reset_vals;
    first_cycle |-> irq_enable_four == '0 && irq_enable_five == '0
                    && irq_priority[0] == 16'h4444 && irq_priority[1] == 16'h4440
                    && irq_priority[2] == 16'h4444;
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("bad value after reset");

  property p_write_back;
    (wr_take && paddr == IRQ_ENABLE_FIVE_OFS) |=>
      irq_enable_five == ($past(pwdata[REG_W-1:0]) & 16'h3FFE);
  endproperty
  a_write_back: assert property (p_write_back) else $error("write not stored");

  property p_unimpl_kept;
    ((irq_enable_four & ~ENABLE_FOUR_MASK) == '0) && ((irq_priority[1] & 16'h888F) == '0);
  endproperty
  a_unimpl_kept: assert property (p_unimpl_kept) else $error("unused bit stored");

  property p_pend_cause;
    prio_pend[0] |-> $past(prio_req[0]) && $past(prio_src_en[0])
                     && ($past(irq_priority[0][14:12]) != PRIO_OFF);
  endproperty
  a_pend_cause: assert property (p_pend_cause) else $error("pending without cause");

  property p_gate_five;
    pend_five == ($past(req_five) & $past(irq_enable_five));
  endproperty
  a_gate_five: assert property (p_gate_five) else $error("gated fifth mismatch");

  property p_gate_blocks;
    ((pend_four & ~$past(irq_enable_four)) == '0)
      && ((pend_five & ~$past(irq_enable_five)) == '0);
  endproperty
  a_gate_blocks: assert property (p_gate_blocks) else $error("request not blocked");

  property p_ready_answer;
    (psel && !penable) |=> pready;
  endproperty
  a_ready_answer: assert property (p_ready_answer) else $error("setup not answered");

  property p_ready_pulse;
    pready |=> !pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready held too long");

  property p_read_four;
    (psel && penable && pready && !pwrite && paddr == IRQ_ENABLE_FOUR_OFS)
      |-> prdata[REG_W-1:0] == irq_enable_four;
  endproperty
  a_read_four: assert property (p_read_four) else $error("read differs from stored");

  property p_write_four;
    (wr_take && paddr == IRQ_ENABLE_FOUR_OFS) |=>
      irq_enable_four == ($past(pwdata[REG_W-1:0]) & 16'h210E);
  endproperty
  a_write_four: assert property (p_write_four) else $error("enable write lost");

  property p_write_two;
    (wr_take && paddr == IRQ_PRIORITY_TWO_OFS) |=>
      irq_priority[2] == ($past(pwdata[REG_W-1:0]) & 16'h7777);
  endproperty
  a_write_two: assert property (p_write_two) else $error("priority write lost");

  property p_bad_write;
    (psel && penable && pready && pwrite && pslverr) |=>
      $stable(irq_enable_four) && $stable(irq_enable_five) && $stable(irq_priority[0])
      && $stable(irq_priority[1]) && $stable(irq_priority[2]);
  endproperty
  a_bad_write: assert property (p_bad_write) else $error("refused write stored");

  property p_map_zero;
    !first_cycle |-> prio_level[4*PRIO_W-1:0]
      == {$past(irq_priority[0][2:0]), $past(irq_priority[0][6:4]),
          $past(irq_priority[0][10:8]), $past(irq_priority[0][14:12])};
  endproperty
  a_map_zero: assert property (p_map_zero) else $error("zero sources misplaced");

  property p_map_one;
    !first_cycle |-> prio_level[7*PRIO_W-1 -: 3*PRIO_W]
      == {$past(irq_priority[1][6:4]), $past(irq_priority[1][10:8]),
          $past(irq_priority[1][14:12])};
  endproperty
  a_map_one: assert property (p_map_one) else $error("one sources misplaced");

  property p_map_two;
    !first_cycle |-> prio_level[PRIO_SRCS*PRIO_W-1 -: 4*PRIO_W]
      == {$past(irq_priority[2][2:0]), $past(irq_priority[2][6:4]),
          $past(irq_priority[2][10:8]), $past(irq_priority[2][14:12])};
  endproperty
  a_map_two: assert property (p_map_two) else $error("two sources misplaced");

  // Zero field silences its source
  generate
    for (gi = 0; gi < PRIO_SRCS; gi++) begin : g_chk
      property p_src_off;
        (g_src[gi].field == PRIO_OFF)
          |=> !prio_pend[gi] && (prio_level[gi*PRIO_W +: PRIO_W] == PRIO_OFF);
      endproperty
      a_src_off: assert property (p_src_off) else $error("disabled source pending");
    end
  endgenerate

  c_write_read: cover property (wr_take ##[1:4] (psel && penable && pready && !pwrite));
  c_bad_addr:   cover property (psel && penable && pslverr);
  c_pend_top:   cover property (prio_pend[0] && prio_level[0 +: PRIO_W] == 3'h7);
  c_gate_five:  cover property (pend_five[USB_IRQ_EN]);
  c_src_off:    cover property (prio_req[0] && prio_src_en[0] && prio_level[2:0] == PRIO_OFF);

endmodule

// file: verif/irq_src_model.sv
// Peripheral request sources that face the interrupt enable and priority block
`timescale 1ns/10ps
module irq_src_model
  import irq_regs_pkg::*;
(
  input  wire logic                 clk,
  output logic      [REG_W-1:0]     req_four,
  output logic      [REG_W-1:0]     req_five,
  output logic      [PRIO_SRCS-1:0] prio_req,
  output logic      [PRIO_SRCS-1:0] prio_src_en
);
  int seed = 32'h28DB;

  initial begin
    req_four = '0;
    req_five = '0;
    prio_req = '0;
    prio_src_en = '0;
  end

  // Request levels wander every cycle, including unimplemented positions
  always @(posedge clk) begin
    req_four <= REG_W'($random(seed));
    req_five <= REG_W'($random(seed));
    prio_req <= PRIO_SRCS'($random(seed));
    prio_src_en <= PRIO_SRCS'($random(seed));
  end
endmodule

// file: verif/irq_enable_priority_regs_bench.sv
// Self-checking bench of the interrupt enable and priority registers
`timescale 1ns/10ps
module irq_enable_priority_regs_bench
  import irq_regs_pkg::*;
;
  typedef struct packed {logic wr; logic err; logic [DATA_W-1:0] data;} note_type;
  localparam logic [REG_W-1:0] mask_tab  [5] = '{16'h210E, 16'h3FFE, 16'h7777, 16'h7770, 16'h7777};
  localparam logic [REG_W-1:0] reset_tab [5] = '{16'h0000, 16'h0000, 16'h4444, 16'h4440, 16'h4444};

  logic                        clk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic [ADDR_W-1:0]           paddr;
  logic [DATA_W-1:0]           pwdata, prdata;
  logic [REG_W-1:0]            req_four, req_five, pend_four, pend_five, exp_four, exp_five;
  logic [PRIO_SRCS-1:0]        prio_req, prio_src_en, prio_pend, exp_pend;
  logic [PRIO_SRCS*PRIO_W-1:0] prio_level, exp_level;
  logic [REG_W-1:0]            sh  [5];
  logic [REG_W-1:0]            drv [5];
  note_type                    notes [$];
  int                          fails, total_checks, cycles, seed;

  irq_enable_priority_regs dut_u (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .req_four(req_four), .req_five(req_five), .pend_four(pend_four),
    .pend_five(pend_five), .prio_req(prio_req), .prio_src_en(prio_src_en),
    .prio_pend(prio_pend), .prio_level(prio_level));

  irq_src_model src_u (.clk(clk), .req_four(req_four), .req_five(req_five),
    .prio_req(prio_req), .prio_src_en(prio_src_en));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic ok, input string what);
    total_checks++;
    if (ok !== 1'b1) begin
      fails++;
      $display("[FAIL] %0t %s", $time, what);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Source order: priority zero top down, priority one upper three, priority two
  function automatic logic [PRIO_SRCS*PRIO_W-1:0] levels();
    logic [PRIO_SRCS*PRIO_W-1:0] lv;
    int k;
    k = 0;
    for (int r = 2; r < 5; r++)
      for (int f = 3; f >= 0; f--)
        if (!(r == 3 && f == 0)) begin
          lv[k*3 +: 3] = sh[r][f*4 +: 3];
          k++;
        end
    return lv;
  endfunction

  task automatic xfer(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                      input bit chain);
    note_type n;
    int i;
    i = a[ADDR_W-1:2];
    n.wr = wr;
    n.err = (a[1:0] != 2'b00) || (i > 4);
    n.data = n.err ? '0 : {16'h0000, drv[i]};
    if (wr && !n.err) drv[i] = d[REG_W-1:0] & mask_tab[i];
    notes.push_back(n);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    if (!chain) begin
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles > 3000) begin
      fails++;
      conclude();
    end
  end

  // Output watcher: gating and levels one cycle behind, bus answers off the queue
  always @(posedge clk) begin
    note_type n;
    if (!rst_n) begin
      sh = reset_tab;
      exp_four = '0;
      exp_five = '0;
      exp_pend = '0;
      exp_level = '0;
    end else begin
      check(pend_four === exp_four && pend_five === exp_five, "enable gating");
      check(prio_pend === exp_pend && prio_level === exp_level, "priority out");
      check(pready === (psel && penable), "ready timing");
      exp_four = req_four & sh[0];
      exp_five = req_five & sh[1];
      exp_level = levels();
      for (int s = 0; s < PRIO_SRCS; s++)
        exp_pend[s] = prio_req[s] & prio_src_en[s] & (exp_level[s*3 +: 3] != 3'h0);
      if (psel && penable && pready) begin
        if (notes.size() == 0) begin
          fails++;
          $display("[FAIL] %0t unexpected transfer", $time);
        end else begin
          n = notes.pop_front();
          check(pslverr === n.err, "bus error flag");
          if (!n.wr) check(prdata === n.data, "read data");
          else if (!n.err) sh[paddr[4:2]] = pwdata[REG_W-1:0] & mask_tab[paddr[4:2]];
        end
      end
    end
  end

  initial begin
    logic [DATA_W-1:0] v;
    int a;
    seed = 32'h28DB;
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    drv = reset_tab;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    for (a = 0; a < 5; a++) xfer(1'b0, ADDR_W'(4*a), '0, 1'b1);
    for (a = 0; a < 5; a++) xfer(1'b1, ADDR_W'(4*a), 32'hFFFF_FFFF, 1'b1);
    for (a = 0; a < 5; a++) xfer(1'b0, ADDR_W'(4*a), '0, a < 4);
    repeat (20) @(posedge clk);
    for (int c = 0; c < 8; c++) begin
      for (a = 2; a < 5; a++) xfer(1'b1, ADDR_W'(4*a), {16'h0000, {4{1'b0, 3'(c)}}}, a < 4);
      repeat (8) @(posedge clk);
    end
    repeat (40) begin
      a = $unsigned($random(seed)) % 5;
      v = $random(seed);
      xfer(1'b1, ADDR_W'(4*a), v, 1'b1);
      xfer(1'b0, ADDR_W'(4*a), '0, 1'b0);
      repeat (3) @(posedge clk);
    end
    xfer(1'b1, 12'h014, 32'hFFFF_FFFF, 1'b1);
    xfer(1'b0, 12'h014, '0, 1'b1);
    xfer(1'b1, 12'h006, '0, 1'b1);
    xfer(1'b0, 12'hFFC, '0, 1'b1);
    xfer(1'b0, 12'h004, '0, 1'b0);
    repeat (4) @(posedge clk);
    conclude();
  end
endmodule
